// ---- pkg/eil_pkg.sv ----
`default_nettype none
// ==========================================================================
// Constants and types of the external interrupt latch
package eil_pkg;

	// ======================================================================
	// Register byte offsets
	localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_BREAK_FLAG_CONTROL = 8'h04;
	localparam logic [7:0] OFS_EVENT_STATUS = 8'h08;
	localparam logic [7:0] OFS_EVENT_MASK = 8'h0C;
	localparam logic [7:0] OFS_PIN_LEVEL = 8'h10;

	// ======================================================================
	// Field positions of ext_int_status_control
	localparam int BIT_MODE = 0;
	localparam int BIT_REQUEST_MASK = 1;
	localparam int BIT_ACK = 2;
	localparam int BIT_PENDING_FLAG = 3;
	// Field position of break_flag_control
	localparam int BIT_BREAK_CLEAR_ENABLE = 0;
	// Event bits
	localparam int EVT_LATCH_SET = 0;
	localparam int EVT_LATCH_CLEAR = 1;
	localparam int EVT_W = 2;

	// ======================================================================
	// Vector location, high and low byte
	localparam logic [15:0] VECTOR_HI_ADDR = 16'hFFFA;
	localparam logic [15:0] VECTOR_LO_ADDR = 16'hFFFB;

	// ======================================================================
	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam int ADDR_W = 8;

	// ======================================================================
	// Whole state of the block
	typedef struct packed {
		logic pin_meta;
		logic pin_sync;
		logic pin_prev;
		logic latch;
		logic ack_seen;
		logic mode;
		logic request_mask;
		logic break_clear_enable;
		logic [EVT_W-1:0] evt_sts;
		logic [EVT_W-1:0] evt_msk;
		logic dph_valid;
		logic dph_write;
		logic [ADDR_W-1:0] dph_addr;
		logic [31:0] hrdata;
	} eil_state_t;

	localparam eil_state_t STATE_RESET = '{
		pin_meta: 1'b1,
		pin_sync: 1'b1,
		pin_prev: 1'b1,
		latch: 1'b0,
		ack_seen: 1'b0,
		mode: 1'b0,
		request_mask: 1'b0,
		break_clear_enable: 1'b0,
		evt_sts: 2'h0,
		evt_msk: 2'h0,
		dph_valid: 1'b0,
		dph_write: 1'b0,
		dph_addr: 8'h00,
		hrdata: 32'h0000_0000
	};

endpackage : eil_pkg
`default_nettype wire

// ---- rtl/eil_top.sv ----
// Summary of operation
// - A low pin, qualified by sensitivity, sets the interrupt latch.
// - A vector fetch acknowledge clears the latch.
// - Writing one to the acknowledge bit clears the latch.
// - Reset clears latch and sensitivity bit even with the pin low.
// - Sensitivity bit read/write; one means edge and level, zero edge only.
// - Edge only: latch holds until acknowledge or reset, then clears at once.
// - Edge and level: clear needs acknowledge and pin high, either order.
// - Edge and level: request stays pending while the pin is low.
// - Masked latch is not forwarded to the priority logic.
// - Mask bit read/write, reset clear, one disables requests.
// - Pending flag is read-only, shows the latch regardless of mask.
// - Acknowledge bit is write-only, reads zero, reset clears it.
// - A falling edge after an acknowledge write latches a new request.
// - Serviced request uses the vector at the two given byte addresses.
// - In break state with clear enable zero, software acknowledge is ignored.
// - With clear enable one, break-time clear holds after break ends.
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module eil_top (
	// Clock, reset, enable
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CLK_EN,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA,
	// External pin and processor side
	input wire logic IRQ_PIN_N,
	input wire logic VECTOR_FETCH,
	input wire logic BREAK_STATE,
	output logic CPU_IRQ_REQ,
	output logic [15:0] VECTOR_HI_ADDR,
	output logic [15:0] VECTOR_LO_ADDR,
	// Interrupt to system
	output logic INT_OUT
);

	// ======================================================================
	// Declarations
	eil_pkg::eil_state_t st_r;
	eil_pkg::eil_state_t st_nxt;
	logic addr_take;
	logic wr_phase;
	logic falling_edge;
	logic pin_low;
	logic sw_ack_req;
	logic sw_ack_ok;
	logic any_ack;
	logic clear_ok;

	// Offset match on the low address bits
	function automatic logic sel(input logic [eil_pkg::ADDR_W-1:0] a,
			input logic [eil_pkg::ADDR_W-1:0] ofs);
		sel = (a == ofs);
	endfunction : sel

	// ======================================================================
	// Bus and pin qualifiers
	assign addr_take = HSEL && HREADY && (HTRANS == eil_pkg::HTRANS_NONSEQ ||
		HTRANS == eil_pkg::HTRANS_SEQ);
	assign wr_phase = st_r.dph_valid && st_r.dph_write;
	assign falling_edge = st_r.pin_prev && !st_r.pin_sync;
	assign pin_low = !st_r.pin_sync;
	assign sw_ack_req = wr_phase && sel(st_r.dph_addr, eil_pkg::OFS_STATUS_CONTROL) &&
		HWDATA[eil_pkg::BIT_ACK];
	assign sw_ack_ok = sw_ack_req && (!BREAK_STATE || st_r.break_clear_enable);
	assign any_ack = VECTOR_FETCH || sw_ack_ok;
	// Level mode needs acknowledge and pin high, edge mode acknowledge only
	assign clear_ok = st_r.mode ? ((any_ack || st_r.ack_seen) && !pin_low) : any_ack;

	// ======================================================================
	// Next state
	always_comb begin
		st_nxt = st_r;
		// Two-stage synchroniser then edge history
		st_nxt.pin_meta = IRQ_PIN_N;
		st_nxt.pin_sync = st_r.pin_meta;
		st_nxt.pin_prev = st_r.pin_sync;
		// Latch: new edge or held low level wins over any clear
		st_nxt.latch = falling_edge || (st_r.mode && pin_low) ||
			(st_r.latch && !clear_ok);
		// Remember an acknowledge until the pin returns high
		st_nxt.ack_seen = st_nxt.latch && !falling_edge &&
			(st_r.ack_seen || any_ack);
		// Register writes in the data phase
		if (wr_phase && sel(st_r.dph_addr, eil_pkg::OFS_STATUS_CONTROL)) begin
			st_nxt.mode = HWDATA[eil_pkg::BIT_MODE];
			st_nxt.request_mask = HWDATA[eil_pkg::BIT_REQUEST_MASK];
		end
		if (wr_phase && sel(st_r.dph_addr, eil_pkg::OFS_BREAK_FLAG_CONTROL)) begin
			st_nxt.break_clear_enable = HWDATA[eil_pkg::BIT_BREAK_CLEAR_ENABLE];
		end
		if (wr_phase && sel(st_r.dph_addr, eil_pkg::OFS_EVENT_MASK)) begin
			st_nxt.evt_msk = HWDATA[eil_pkg::EVT_W-1:0];
		end
		// Sticky events: write one clears, a new event wins
		if (wr_phase && sel(st_r.dph_addr, eil_pkg::OFS_EVENT_STATUS)) begin
			st_nxt.evt_sts = st_r.evt_sts & ~HWDATA[eil_pkg::EVT_W-1:0];
		end
		if (st_nxt.latch && !st_r.latch) begin
			st_nxt.evt_sts[eil_pkg::EVT_LATCH_SET] = 1'b1;
		end
		if (!st_nxt.latch && st_r.latch) begin
			st_nxt.evt_sts[eil_pkg::EVT_LATCH_CLEAR] = 1'b1;
		end
		// Address phase capture and read data
		st_nxt.dph_valid = addr_take;
		st_nxt.dph_write = addr_take && HWRITE;
		st_nxt.dph_addr = HADDR[eil_pkg::ADDR_W-1:0];
		st_nxt.hrdata = 32'h0000_0000;
		if (addr_take && !HWRITE) begin
			if (sel(HADDR[eil_pkg::ADDR_W-1:0], eil_pkg::OFS_STATUS_CONTROL)) begin
				st_nxt.hrdata[eil_pkg::BIT_MODE] = st_r.mode;
				st_nxt.hrdata[eil_pkg::BIT_REQUEST_MASK] = st_r.request_mask;
				st_nxt.hrdata[eil_pkg::BIT_ACK] = 1'b0;
				st_nxt.hrdata[eil_pkg::BIT_PENDING_FLAG] = st_r.latch;
			end else if (sel(HADDR[eil_pkg::ADDR_W-1:0], eil_pkg::OFS_BREAK_FLAG_CONTROL)) begin
				st_nxt.hrdata[eil_pkg::BIT_BREAK_CLEAR_ENABLE] = st_r.break_clear_enable;
			end else if (sel(HADDR[eil_pkg::ADDR_W-1:0], eil_pkg::OFS_EVENT_STATUS)) begin
				st_nxt.hrdata[eil_pkg::EVT_W-1:0] = st_r.evt_sts;
			end else if (sel(HADDR[eil_pkg::ADDR_W-1:0], eil_pkg::OFS_EVENT_MASK)) begin
				st_nxt.hrdata[eil_pkg::EVT_W-1:0] = st_r.evt_msk;
			end else if (sel(HADDR[eil_pkg::ADDR_W-1:0], eil_pkg::OFS_PIN_LEVEL)) begin
				st_nxt.hrdata[0] = st_r.pin_sync;
			end
		end
	end

	// ======================================================================
	// State register, synchronous reset, frozen while disabled
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			st_r <= eil_pkg::STATE_RESET;
		end else if (CLK_EN) begin
			st_r <= st_nxt;
		end
	end

	// ======================================================================
	// Outputs
	assign HREADYOUT = CLK_EN;
	assign HRESP = 1'b0;
	assign HRDATA = st_r.hrdata;
	assign CPU_IRQ_REQ = st_r.latch && !st_r.request_mask;
	assign VECTOR_HI_ADDR = eil_pkg::VECTOR_HI_ADDR;
	assign VECTOR_LO_ADDR = eil_pkg::VECTOR_LO_ADDR;
	assign INT_OUT = |(st_r.evt_sts & st_r.evt_msk);

	// ======================================================================
	// Assertions
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	// Edge sets latch at next enabled edge
	AST_EDGE_SETS: assert property (CLK_EN && falling_edge |=> st_r.latch)
		else $error("falling edge did not set latch");
	// Vector fetch clears in edge mode
	AST_VF_CLEARS: assert property (CLK_EN && !st_r.mode && st_r.latch && VECTOR_FETCH &&
		!falling_edge |=> !st_r.latch)
		else $error("vector fetch did not clear latch");
	// Software acknowledge clears in edge mode outside break
	AST_SW_ACK_CLEARS: assert property (CLK_EN && !st_r.mode && sw_ack_req && !BREAK_STATE &&
		!falling_edge |=> !st_r.latch)
		else $error("software acknowledge did not clear latch");
	// Reset clears latch, sensitivity and mask
	AST_RESET_CLEARS: assert property (disable iff (1'b0) RST |=>
		!st_r.latch && !st_r.mode && !st_r.request_mask)
		else $error("reset left latch or control set");
	// Level mode keeps request while pin low
	AST_LEVEL_HOLD: assert property (CLK_EN && st_r.mode && pin_low |=> st_r.latch)
		else $error("level request dropped while pin low");
	// Level mode acknowledge with pin low does not clear
	// Only the second synchroniser stage is watched here, never the first
	AST_LEVEL_NEEDS_HIGH: assert property (CLK_EN && st_r.mode && st_r.latch && any_ack &&
		pin_low |=> st_r.latch)
		else $error("level latch cleared with pin low");
	// Unmasked latch is forwarded to the request
	AST_MASK_GATES: assert property (st_r.latch && !st_r.request_mask |-> CPU_IRQ_REQ)
		else $error("unmasked latch not forwarded");
	// Set mask keeps the request away from the priority logic
	AST_MASK_BLOCKS: assert property (st_r.request_mask |-> !CPU_IRQ_REQ)
		else $error("masked latch forwarded");
	// Mask write takes effect
	AST_MASK_WRITE: assert property (CLK_EN && wr_phase &&
		sel(st_r.dph_addr, eil_pkg::OFS_STATUS_CONTROL) &&
		HWDATA[eil_pkg::BIT_REQUEST_MASK] |=> st_r.request_mask && !CPU_IRQ_REQ)
		else $error("mask write not applied");
	// Pending flag read matches latch, acknowledge reads zero
	AST_READ_STATUS: assert property (CLK_EN && addr_take && !HWRITE &&
		sel(HADDR[eil_pkg::ADDR_W-1:0], eil_pkg::OFS_STATUS_CONTROL) |=>
		HRDATA[eil_pkg::BIT_PENDING_FLAG] == $past(st_r.latch) &&
		!HRDATA[eil_pkg::BIT_ACK])
		else $error("status read wrong");
	// Break with clear enable zero protects latch
	AST_BREAK_PROTECT: assert property (CLK_EN && st_r.latch && sw_ack_req && BREAK_STATE &&
		!st_r.break_clear_enable && !VECTOR_FETCH |=> st_r.latch)
		else $error("latch cleared during protected break");
	// Break clear with enable set clears the latch
	AST_BREAK_CLEAR: assert property (CLK_EN && !st_r.mode && sw_ack_req && BREAK_STATE &&
		st_r.break_clear_enable && !falling_edge |=> !st_r.latch)
		else $error("break clear did not clear latch");

	// Main scenarios
	COV_EDGE_ACK: cover property (falling_edge ##[1:20] sw_ack_ok);
	COV_LEVEL_ACK_FIRST: cover property (st_r.mode && st_r.latch && any_ack && pin_low
		##[1:50] !st_r.latch);
	COV_BREAK_BLOCK: cover property (sw_ack_req && BREAK_STATE && !st_r.break_clear_enable);
	COV_INT_OUT: cover property (INT_OUT);

endmodule : eil_top
`default_nettype wire

// ---- sim/eil_pin_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module eil_pin_src (
	// Clock
	input wire logic CLK_SYS,
	// Bench command and pin
	input wire logic DRIVE_LOW,
	output logic PIN_N = 1'b1
);
	// =====================================================================
	// Registered push-pull source; the released pin is driven high
	always_ff @(posedge CLK_SYS) begin
		PIN_N <= ~DRIVE_LOW;
	end
endmodule : eil_pin_src
`default_nettype wire

// ---- sim/eil_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module eil_test;
	// =====================================================================
	// Bench signals
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic vfetch = 1'b0;
	logic brk = 1'b0;
	logic src_low = 1'b0;
	logic cen = 1'b1;
	logic [2:0] hsize = 3'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	wire logic hreadyout;
	wire logic hresp;
	wire logic pin_n;
	wire logic irq;
	wire logic int_out;
	wire logic [31:0] hrdata;
	wire logic [15:0] vhi;
	wire logic [15:0] vlo;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;

	// Clock
	always #5 clk_sys = ~clk_sys;

	// =====================================================================
	// Design and pin source
	eil_top DUT (.CLK_SYS(clk_sys), .RST(rst), .CLK_EN(cen), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
		.HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .IRQ_PIN_N(pin_n),
		.VECTOR_FETCH(vfetch), .BREAK_STATE(brk), .CPU_IRQ_REQ(irq), .VECTOR_HI_ADDR(vhi),
		.VECTOR_LO_ADDR(vlo), .INT_OUT(int_out));
	eil_pin_src SRC (.CLK_SYS(clk_sys), .DRIVE_LOW(src_low), .PIN_N(pin_n));

	// =====================================================================
	// Tasks
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One single AHB transfer, address phase then data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= eil_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : rdc
	task wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt
	task drive(input logic v);
		@(posedge clk_sys);
		src_low <= v;
		wt(6);
	endtask : drive
	task print_verdict;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	// Hang guard
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			print_verdict();
		end
	end

	// =====================================================================
	// Main sequence
	initial begin
		wt(8);
		rst <= 1'b0;
		rdc("status at reset", eil_pkg::OFS_STATUS_CONTROL, 32'h0);
		rdc("break ctl at reset", eil_pkg::OFS_BREAK_FLAG_CONTROL, 32'h0);
		// Clock enable low freezes the bus answer
		@(posedge clk_sys);
		cen <= 1'b0;
		wt(2);
		chk("ready frozen", 32'h0, {31'h0, hreadyout});
		cen <= 1'b1;
		wr(8'h40, 32'hFF);
		rdc("unmapped", 8'h40, 32'h0);
		chk("vector hi", 32'h0000FFFA, {16'h0, vhi});
		chk("vector lo", 32'h0000FFFB, {16'h0, vlo});
		wr(eil_pkg::OFS_EVENT_MASK, 32'h3);
		// Edge mode: latch, mask, software acknowledge
		drive(1'b1);
		chk("irq on edge", 32'h1, {31'h0, irq});
		chk("int out", 32'h1, {31'h0, int_out});
		rdc("pending", eil_pkg::OFS_STATUS_CONTROL, 32'h8);
		wr(eil_pkg::OFS_STATUS_CONTROL, 32'h2);
		wt(1);
		chk("irq masked", 32'h0, {31'h0, irq});
		rdc("pending masked", eil_pkg::OFS_STATUS_CONTROL, 32'hA);
		wr(eil_pkg::OFS_STATUS_CONTROL, 32'h6);
		rdc("after ack", eil_pkg::OFS_STATUS_CONTROL, 32'h2);
		wr(eil_pkg::OFS_STATUS_CONTROL, 32'h0);
		rdc("events", eil_pkg::OFS_EVENT_STATUS, 32'h3);
		wr(eil_pkg::OFS_EVENT_STATUS, 32'h3);
		wt(1);
		chk("int out cleared", 32'h0, {31'h0, int_out});
		// New edge after acknowledge, then vector fetch
		drive(1'b0);
		drive(1'b1);
		chk("irq new edge", 32'h1, {31'h0, irq});
		@(posedge clk_sys);
		vfetch <= 1'b1;
		@(posedge clk_sys);
		vfetch <= 1'b0;
		wt(1);
		chk("irq after fetch", 32'h0, {31'h0, irq});
		// Level mode: ack while low, release, then release without ack
		wr(eil_pkg::OFS_STATUS_CONTROL, 32'h1);
		wt(4);
		chk("irq level", 32'h1, {31'h0, irq});
		wr(eil_pkg::OFS_STATUS_CONTROL, 32'h5);
		wt(4);
		chk("irq ack pin low", 32'h1, {31'h0, irq});
		drive(1'b0);
		chk("irq ack then high", 32'h0, {31'h0, irq});
		drive(1'b1);
		drive(1'b0);
		chk("irq high no ack", 32'h1, {31'h0, irq});
		wr(eil_pkg::OFS_STATUS_CONTROL, 32'h7);
		rdc("high then ack", eil_pkg::OFS_STATUS_CONTROL, 32'h3);
		wr(eil_pkg::OFS_STATUS_CONTROL, 32'h0);
		// Break state protection and break clear enable
		drive(1'b1);
		@(posedge clk_sys);
		brk <= 1'b1;
		wr(eil_pkg::OFS_STATUS_CONTROL, 32'h4);
		rdc("ack in break", eil_pkg::OFS_STATUS_CONTROL, 32'h8);
		wr(eil_pkg::OFS_BREAK_FLAG_CONTROL, 32'h1);
		wr(eil_pkg::OFS_STATUS_CONTROL, 32'h4);
		@(posedge clk_sys);
		brk <= 1'b0;
		rdc("cleared after break", eil_pkg::OFS_STATUS_CONTROL, 32'h0);
		// Reset with the pin held low in level mode
		wr(eil_pkg::OFS_STATUS_CONTROL, 32'h1);
		wt(4);
		@(posedge clk_sys);
		rst <= 1'b1;
		wt(2);
		chk("irq in reset", 32'h0, {31'h0, irq});
		@(posedge clk_sys);
		rst <= 1'b0;
		bus(1'b0, eil_pkg::OFS_STATUS_CONTROL, 32'h0);
		chk("mode after reset", 32'h0, rd & 32'h1);
		print_verdict();
	end
endmodule : eil_test
`default_nettype wire
